// File: hw/fsr_pkg.sv
// Package: offsets, field positions, defaults, commands and timing constants for the status register bank
`default_nettype none
package fsr_pkg;
   // ------------------------------------------------------------
   // Register selection codes on the command port
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_ONE = 2'h0;
   localparam logic [1:0] SEL_TWO = 2'h1;
   localparam logic [1:0] SEL_THREE = 2'h2;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int GUARD0_POS = 7;
   localparam int BP_HI = 6;
   localparam int BP_LO = 2;
   localparam int WEL_POS = 1;
   localparam int BUSY_POS = 0;
   localparam int PAUSE_POS = 7;
   localparam int INV_POS = 6;
   localparam int LOCK_HI = 5;
   localparam int LOCK_LO = 3;
   localparam int QE_POS = 1;
   localparam int GUARD1_POS = 0;
   localparam int PINSEL_POS = 7;
   // ------------------------------------------------------------
   // Factory defaults of the non-volatile bits
   // ------------------------------------------------------------
   localparam logic [7:0] NV_ONE_DEFAULT = 8'h00;
   localparam logic [7:0] NV_TWO_DEFAULT = 8'h00;
   localparam logic [7:0] NV_THREE_DEFAULT = 8'h00;
   // ------------------------------------------------------------
   // Command opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7A;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   // ------------------------------------------------------------
   // Serial transfer and write timing
   // ------------------------------------------------------------
   localparam int SHIFT_BITS = 8;
   localparam int CLK_MHZ = 100;
   localparam int WRSR_TIME_NS = 200;
   localparam int WRSR_CYCLES = (WRSR_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] WRSR_CNT = 8'(WRSR_CYCLES);
   typedef enum logic [1:0] {
      FSR_IDLE = 2'b00,
      FSR_SHIFT = 2'b01,
      FSR_COMMIT = 2'b11
   } fsr_state_e;
endpackage : fsr_pkg
`default_nettype wire

// File: hw/fsr_shift_if.sv
// Interface: carries one serial register byte between the bank and its shifter
`default_nettype none
interface fsr_shift_if;
   logic load;
   logic [7:0] load_val;
   logic step;
   logic sin;
   logic sout;
   logic [7:0] word;
   modport bank (output load, output load_val, output step, output sin, input sout, input word);
   modport shifter (input load, input load_val, input step, input sin, output sout, output word);
endinterface : fsr_shift_if
`default_nettype wire

// File: hw/fsr_shifter.sv
// Shifter: eight-bit MSB-first shift register for register reads and writes
`default_nettype none
module fsr_shifter (
   input wire logic clk,
   input wire logic reset_n,
   fsr_shift_if.shifter sh
);
   logic [7:0] sr_q;
   logic [7:0] sr_d;

   // MSB leaves first, new bit enters at the bottom
   assign sr_d = sh.load ? sh.load_val : (sh.step ? {sr_q[6:0], sh.sin} : sr_q);
   assign sh.sout = sr_q[7];
   assign sh.word = sr_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sr_q <= 8'h00;
      end else begin
         sr_q <= sr_d;
      end
   end
endmodule : fsr_shifter
`default_nettype wire

// File: hw/fsr_regs.sv
// Top: three status and configuration registers of a serial flash, with protection decoding
// Operation
// - Guard bit zero at status one bit seven
// - Five block protect bits at 6:2
// - Block protect writes blocked in hardware mode
// - Chip erase only for matching protect pattern
// - Array unprotected right after power-up
// - Write latch read-only; zero rejects writes
// - Busy flag set during program, erase, write
// - Suspend command sets paused flag only while busy
// - Resume, reset sequence, resets clear paused flag
// - Invert protection non-volatile, default zero
// - Three lock bits, settable to one
// - Lock bits return to zero only at power-up reset
// - Quad enable turns pins into data
// - Guard bit one at status two bit zero
// - Pin select: hold or reset function
// - Hold/reset function only without quad enable
// - Non-volatile defaults come from factory
// - Guard pair decodes four protection modes
// - Power-supply lock-down reverts at power cycle
`default_nettype none
module fsr_regs (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic POWER_UP,
   input wire logic OP_VALID,
   input wire logic [7:0] OP_CODE,
   input wire logic XFER_START,
   input wire logic XFER_WRITE,
   input wire logic [1:0] XFER_SEL,
   input wire logic XFER_BIT,
   input wire logic SER_IN,
   input wire logic XFER_END,
   input wire logic WP_PIN,
   input wire logic ARRAY_BUSY,
   input wire logic CHIP_ERASE_REQ,
   input wire logic [2:0] LOCK_SET_REQ,
   output logic SER_OUT,
   output logic [7:0] STATUS_ONE,
   output logic [7:0] STATUS_TWO,
   output logic [7:0] STATUS_THREE,
   output logic WRITE_ALLOWED,
   output logic CHIP_ERASE_GO,
   output logic HOLD_FUNC_EN,
   output logic RESET_FUNC_EN,
   output logic QUAD_PINS_EN,
   output logic [2:0] SEC_READ_ONLY
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic guard0_q;
   logic guard1_q;
   logic [4:0] bp_q;
   logic inv_q;
   logic [2:0] lock_q;
   logic qe_q;
   logic pinsel_q;
   logic wel_q;
   logic wel_d;
   logic pause_q;
   logic pause_d;
   logic rst_armed_q;
   logic wbusy_q;
   logic [7:0] wcnt_q;
   logic [7:0] wcnt_d;
   logic [3:0] bits_q;
   logic [1:0] sel_q;
   logic wr_q;
   logic pwr_locked_q;
   fsr_pkg::fsr_state_e st_q;
   fsr_pkg::fsr_state_e st_d;
   fsr_shift_if sh ();

   // ------------------------------------------------------------
   // Decodes
   // ------------------------------------------------------------
   function automatic logic [7:0] reg_view(input logic [1:0] sel, input logic [7:0] s1, input logic [7:0] s2,
                                           input logic [7:0] s3);
      logic [7:0] v;
      v = 8'h00;
      unique case (sel)
         fsr_pkg::SEL_ONE: v = s1;
         fsr_pkg::SEL_TWO: v = s2;
         fsr_pkg::SEL_THREE: v = s3;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : reg_view

   wire busy = ARRAY_BUSY | wbusy_q;
   wire [7:0] s1_w = {guard0_q, bp_q, wel_q, busy};
   wire [7:0] s2_w = {pause_q, inv_q, lock_q, 1'b0, qe_q, guard1_q};
   wire [7:0] s3_w = {pinsel_q, 7'h00};
   wire op_rst_seq = OP_VALID & (OP_CODE == fsr_pkg::OP_RST) & rst_armed_q;
   wire sw_reset = op_rst_seq;
   // Guard pair decode: 00 software, 01 pin, 10 until power cycle, 11 forever
   wire hw_locked = (guard1_q == 1'b0) & guard0_q & ~WP_PIN;
   wire guard_open = (guard1_q == 1'b0) & (~guard0_q | WP_PIN);
   wire wr_ok = guard_open & wel_q & ~busy;
   wire [2:0] bp_lo = bp_q[2:0];
   wire erase_ok = inv_q ? (bp_lo == 3'h7) : (bp_lo == 3'h0);
   wire start = XFER_START & (st_q == fsr_pkg::FSR_IDLE);
   wire commit = st_q == fsr_pkg::FSR_COMMIT;
   wire do_write = commit & wr_q & (bits_q == 4'(fsr_pkg::SHIFT_BITS)) & wr_ok;
   wire [7:0] wv = sh.word;
   wire [2:0] lock_new = lock_q | wv[fsr_pkg::LOCK_HI:fsr_pkg::LOCK_LO];

   // ------------------------------------------------------------
   // Serial byte path
   // ------------------------------------------------------------
   assign sh.load = start;
   assign sh.load_val = reg_view(XFER_SEL, s1_w, s2_w, s3_w);
   assign sh.step = (st_q == fsr_pkg::FSR_SHIFT) & XFER_BIT & (bits_q < 4'(fsr_pkg::SHIFT_BITS));
   assign sh.sin = SER_IN;

   fsr_shifter u_shift (
      .clk(CLK),
      .reset_n(RESET_N),
      .sh(sh)
   );

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         fsr_pkg::FSR_IDLE: if (start) st_d = fsr_pkg::FSR_SHIFT;
         fsr_pkg::FSR_SHIFT: if (XFER_END) st_d = fsr_pkg::FSR_COMMIT;
         fsr_pkg::FSR_COMMIT: st_d = fsr_pkg::FSR_IDLE;
         default: st_d = fsr_pkg::FSR_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         st_q <= fsr_pkg::FSR_IDLE;
         bits_q <= 4'h0;
         sel_q <= 2'h0;
         wr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (start) begin
            bits_q <= 4'h0;
            sel_q <= XFER_SEL;
            wr_q <= XFER_WRITE;
         end else if (sh.step) begin
            bits_q <= bits_q + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Write latch, paused flag, reset sequence, write timer
   // ------------------------------------------------------------
   // Latch drops after any accepted write and on any reset
   always_comb begin
      wel_d = wel_q;
      if (OP_VALID & (OP_CODE == fsr_pkg::OP_WREN)) wel_d = 1'b1;
      if (OP_VALID & (OP_CODE == fsr_pkg::OP_WRDI)) wel_d = 1'b0;
      if (do_write | sw_reset) wel_d = 1'b0;
   end

   // Suspend wins if it lands together with a clear
   always_comb begin
      pause_d = pause_q;
      if ((OP_VALID & (OP_CODE == fsr_pkg::OP_RESUME)) | sw_reset) pause_d = 1'b0;
      if (OP_VALID & (OP_CODE == fsr_pkg::OP_SUSPEND) & busy) pause_d = 1'b1;
   end

   assign wcnt_d = do_write ? fsr_pkg::WRSR_CNT : (wcnt_q != 8'h00 ? wcnt_q - 8'h01 : 8'h00);

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         wel_q <= 1'b0;
         pause_q <= 1'b0;
         rst_armed_q <= 1'b0;
         wcnt_q <= 8'h00;
         wbusy_q <= 1'b0;
      end else begin
         wel_q <= wel_d;
         pause_q <= pause_d;
         if (OP_VALID) rst_armed_q <= (OP_CODE == fsr_pkg::OP_RST_EN);
         wcnt_q <= wcnt_d;
         wbusy_q <= wcnt_d != 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Non-volatile bits
   // ------------------------------------------------------------
   // Only power-up reset reloads factory image; a real part keeps them in cells,
   // so RESET_N alone leaves them; of the resets only POWER_UP and its lock-down release touch them here.
   always_ff @(posedge CLK) begin
      if (!RESET_N && POWER_UP) begin
         {guard0_q, bp_q} <= {fsr_pkg::NV_ONE_DEFAULT[7], fsr_pkg::NV_ONE_DEFAULT[6:2]};
         inv_q <= fsr_pkg::NV_TWO_DEFAULT[fsr_pkg::INV_POS];
         lock_q <= fsr_pkg::NV_TWO_DEFAULT[fsr_pkg::LOCK_HI:fsr_pkg::LOCK_LO];
         qe_q <= fsr_pkg::NV_TWO_DEFAULT[fsr_pkg::QE_POS];
         guard1_q <= fsr_pkg::NV_TWO_DEFAULT[fsr_pkg::GUARD1_POS];
         pinsel_q <= fsr_pkg::NV_THREE_DEFAULT[fsr_pkg::PINSEL_POS];
         pwr_locked_q <= 1'b0;
      end else if (POWER_UP) begin
         // Lock-down setting 10 falls back to 00 across a power cycle
         if (guard1_q & ~guard0_q) guard1_q <= 1'b0;
         pwr_locked_q <= 1'b0;
      end else if (do_write) begin
         unique case (sel_q)
            fsr_pkg::SEL_ONE: begin
               guard0_q <= wv[fsr_pkg::GUARD0_POS];
               if (!hw_locked) bp_q <= wv[fsr_pkg::BP_HI:fsr_pkg::BP_LO];
            end
            fsr_pkg::SEL_TWO: begin
               inv_q <= wv[fsr_pkg::INV_POS];
               lock_q <= lock_new;
               qe_q <= wv[fsr_pkg::QE_POS];
               guard1_q <= wv[fsr_pkg::GUARD1_POS];
               pwr_locked_q <= wv[fsr_pkg::GUARD1_POS];
            end
            fsr_pkg::SEL_THREE: pinsel_q <= wv[fsr_pkg::PINSEL_POS];
            default: pinsel_q <= pinsel_q;
         endcase
      end else if (|LOCK_SET_REQ) begin
         lock_q <= lock_q | LOCK_SET_REQ;
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         SER_OUT <= 1'b0;
         STATUS_ONE <= 8'h00;
         STATUS_TWO <= 8'h00;
         STATUS_THREE <= 8'h00;
         WRITE_ALLOWED <= 1'b0;
         CHIP_ERASE_GO <= 1'b0;
         HOLD_FUNC_EN <= 1'b0;
         RESET_FUNC_EN <= 1'b0;
         QUAD_PINS_EN <= 1'b0;
         SEC_READ_ONLY <= 3'h0;
      end else begin
         SER_OUT <= sh.sout;
         STATUS_ONE <= s1_w;
         STATUS_TWO <= s2_w;
         STATUS_THREE <= s3_w;
         WRITE_ALLOWED <= wel_q & ~busy;
         CHIP_ERASE_GO <= CHIP_ERASE_REQ & erase_ok & wel_q & ~busy;
         HOLD_FUNC_EN <= ~qe_q & ~pinsel_q;
         RESET_FUNC_EN <= ~qe_q & pinsel_q;
         QUAD_PINS_EN <= qe_q;
         SEC_READ_ONLY <= lock_q;
      end
   end
endmodule : fsr_regs
`default_nettype wire

// File: tb/fsr_regs_asserts.sv
// Checker: concurrent properties on the status register bank ports
`default_nettype none
module fsr_regs_asserts (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic OP_VALID,
   input wire logic [7:0] OP_CODE,
   input wire logic ARRAY_BUSY,
   input wire logic CHIP_ERASE_REQ,
   input wire logic [2:0] LOCK_SET_REQ,
   input wire logic [7:0] STATUS_ONE,
   input wire logic [7:0] STATUS_TWO,
   input wire logic [7:0] STATUS_THREE,
   input wire logic CHIP_ERASE_GO,
   input wire logic HOLD_FUNC_EN,
   input wire logic RESET_FUNC_EN,
   input wire logic QUAD_PINS_EN,
   input wire logic [2:0] SEC_READ_ONLY
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);
   a_lock_sticky: assert property (
      SEC_READ_ONLY != 3'h0 |=> (SEC_READ_ONLY & $past(SEC_READ_ONLY)) == $past(SEC_READ_ONLY))
      else $error("lock bit returned to zero");
   a_lock_set: assert property (LOCK_SET_REQ[2] |-> ##[1:3] SEC_READ_ONLY[2])
      else $error("lock bit not set");
   a_quad_pins: assert property ($past(RESET_N) |-> QUAD_PINS_EN == STATUS_TWO[1])
      else $error("quad pin decode wrong");
   a_pin_func: assert property ($past(RESET_N) |->
      {HOLD_FUNC_EN, RESET_FUNC_EN} == ({2{!STATUS_TWO[1]}} & {!STATUS_THREE[7], STATUS_THREE[7]}))
      else $error("hold or reset decode wrong");
   a_erase_gate: assert property (CHIP_ERASE_GO |->
      ($past(CHIP_ERASE_REQ) || $past(CHIP_ERASE_REQ, 2)) && STATUS_ONE[4:2] == {3{STATUS_TWO[6]}})
      else $error("erase granted on bad pattern");
   a_busy_flag: assert property (ARRAY_BUSY ##1 ARRAY_BUSY |-> ##[0:2] STATUS_ONE[0])
      else $error("busy flag missing");
   a_pause_set: assert property (OP_VALID && OP_CODE == 8'h75 && ARRAY_BUSY |-> ##[1:3] STATUS_TWO[7])
      else $error("paused flag not set");
   a_pause_clear: assert property (OP_VALID && OP_CODE == 8'h7A |-> ##[1:3] !STATUS_TWO[7])
      else $error("paused flag not cleared");
endmodule : fsr_regs_asserts
bind fsr_regs fsr_regs_asserts fsr_regs_asserts_inst (.CLK(CLK), .RESET_N(RESET_N), .OP_VALID(OP_VALID),
   .OP_CODE(OP_CODE), .ARRAY_BUSY(ARRAY_BUSY), .CHIP_ERASE_REQ(CHIP_ERASE_REQ), .LOCK_SET_REQ(LOCK_SET_REQ),
   .STATUS_ONE(STATUS_ONE), .STATUS_TWO(STATUS_TWO), .STATUS_THREE(STATUS_THREE),
   .CHIP_ERASE_GO(CHIP_ERASE_GO), .HOLD_FUNC_EN(HOLD_FUNC_EN), .RESET_FUNC_EN(RESET_FUNC_EN),
   .QUAD_PINS_EN(QUAD_PINS_EN), .SEC_READ_ONLY(SEC_READ_ONLY));
`default_nettype wire

// File: tb/fsr_host.sv
// Host model: opcode pulses and MSB-first register transfers
`default_nettype none
module fsr_host (
   input wire logic clk,
   input wire logic ser_out,
   output logic op_valid,
   output logic [7:0] op_code,
   output logic xfer_start,
   output logic xfer_write,
   output logic [1:0] xfer_sel,
   output logic xfer_bit,
   output logic ser_in,
   output logic xfer_end
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {op_valid, op_code, xfer_start, xfer_write, xfer_sel, xfer_bit, ser_in, xfer_end} = '0;
   end
   task automatic op(input logic [7:0] c);
      @(negedge clk);
      op_valid = 1'b1;
      op_code = c;
      @(negedge clk);
      op_valid = 1'b0;
      op_code = ~c;
   endtask : op
   task automatic xfer(input logic w, input logic [1:0] s, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      xfer_start = 1'b1;
      xfer_write = w;
      xfer_sel = s;
      @(negedge clk);
      xfer_start = 1'b0;
      xfer_bit = 1'b1;
      // Read bit appears one edge after the edge that loads or shifts it
      for (int i = 7; i >= 0; i--) begin
         ser_in = d[i];
         @(negedge clk);
         q[i] = ser_out;
      end
      xfer_bit = 1'b0;
      xfer_end = 1'b1;
      // Idle data line toggles so a stale bit is never mistaken for data
      ser_in = ~ser_in;
      @(negedge clk);
      xfer_end = 1'b0;
      repeat (2) @(negedge clk);
   endtask : xfer
endmodule : fsr_host
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: checks the status register bank through the host model
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, power_up, wp_pin, array_busy, erase_req, ser_out, seen;
   logic op_valid, xfer_start, xfer_write, xfer_bit, ser_in, xfer_end, erase_go, wr_allowed;
   logic [7:0] op_code, st1, st2, st3, q;
   logic [1:0] xfer_sel;
   logic [2:0] lock_req;
   int err_count, check_count;
   // Nibbles: latch set, register, then data and read-back
   logic [23:0] rows [7] = '{24'h114242, 24'h12FF80, 24'h107F7C, 24'h001C7C, 24'h110000, 24'h120000, 24'h100000};
   // Register two, register one, erase expected
   logic [19:0] ecase [4] = '{20'h00001, 20'h00040, 20'h401C1, 20'h40000};
   fsr_regs fsr_regs_inst (.CLK(clk), .RESET_N(reset_n), .POWER_UP(power_up), .OP_VALID(op_valid),
      .OP_CODE(op_code), .XFER_START(xfer_start), .XFER_WRITE(xfer_write), .XFER_SEL(xfer_sel),
      .XFER_BIT(xfer_bit), .SER_IN(ser_in), .XFER_END(xfer_end), .WP_PIN(wp_pin), .ARRAY_BUSY(array_busy),
      .CHIP_ERASE_REQ(erase_req), .LOCK_SET_REQ(lock_req), .SER_OUT(ser_out), .STATUS_ONE(st1),
      .STATUS_TWO(st2), .STATUS_THREE(st3), .WRITE_ALLOWED(wr_allowed), .CHIP_ERASE_GO(erase_go), .HOLD_FUNC_EN(),
      .RESET_FUNC_EN(), .QUAD_PINS_EN(), .SEC_READ_ONLY());
   fsr_host fsr_host_inst (.clk(clk), .ser_out(ser_out), .op_valid(op_valid), .op_code(op_code),
      .xfer_start(xfer_start), .xfer_write(xfer_write), .xfer_sel(xfer_sel), .xfer_bit(xfer_bit),
      .ser_in(ser_in), .xfer_end(xfer_end));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   // Accept flag x: outcome left open, busy compared only once it drops
   task automatic wr(input logic e, input logic a, input logic [1:0] s, input logic [7:0] d);
      if (e) fsr_host_inst.op(fsr_pkg::OP_WREN);
      fsr_host_inst.xfer(1'b1, s, d, q);
      repeat (2) @(negedge clk);
      if (a !== 1'bx) chk(8'(st1[0]), 8'(a));
      for (int i = 0; i < 40 && st1[0] !== 1'b0; i++) @(negedge clk);
      chk(8'(st1[0]), 8'h00);
      if (st1[0] !== 1'b0) conclude;
   endtask : wr
   task automatic rst(input logic p, input int n);
      @(negedge clk);
      reset_n = 1'b0;
      power_up = p;
      repeat (n) @(negedge clk);
      reset_n = 1'b1;
      power_up = 1'b0;
      repeat (2) @(negedge clk);
   endtask : rst
   initial begin
      {reset_n, power_up, wp_pin, array_busy, erase_req, lock_req} = {5'b01100, 3'h0};
      err_count = 0;
      check_count = 0;
      rst(1'b1, 5);
      chk(st1 | st2 | st3, 8'h00);
      // Protect pin is driven here, never tied, so quad enable is safe
      foreach (rows[i]) begin
         wr(rows[i][20], rows[i][20], rows[i][17:16], rows[i][15:8]);
         fsr_host_inst.xfer(1'b0, rows[i][17:16], 8'hA5, q);
         chk(q, rows[i][7:0]);
      end
      $display("Row table done");
      fsr_host_inst.op(fsr_pkg::OP_WREN);
      repeat (2) @(negedge clk);
      chk(8'(wr_allowed), 8'h01);
      fsr_host_inst.op(fsr_pkg::OP_WRDI);
      repeat (2) @(negedge clk);
      chk(8'(wr_allowed), 8'h00);
      $display("Latch cases done");
      foreach (ecase[k]) begin
         wr(1'b1, 1'b1, 2'h1, ecase[k][19:12]);
         wr(1'b1, 1'b1, 2'h0, ecase[k][11:4]);
         fsr_host_inst.op(fsr_pkg::OP_WREN);
         erase_req = 1'b1;
         @(negedge clk);
         erase_req = 1'b0;
         seen = 1'b0;
         repeat (3) begin
            seen = seen | erase_go;
            @(negedge clk);
         end
         chk(8'(seen), 8'(ecase[k][0]));
      end
      $display("Erase cases done");
      array_busy = 1'b1;
      for (int k = 0; k < 3; k++) begin
         fsr_host_inst.op(fsr_pkg::OP_SUSPEND);
         repeat (2) @(negedge clk);
         chk(8'(st2[7]), 8'h01);
         if (k == 0) fsr_host_inst.op(fsr_pkg::OP_RESUME);
         if (k == 1) fsr_host_inst.op(fsr_pkg::OP_RST_EN);
         if (k == 1) fsr_host_inst.op(fsr_pkg::OP_RST);
         if (k == 2) rst(1'b0, 2);
         repeat (2) @(negedge clk);
         chk(8'(st2[7]), 8'h00);
      end
      array_busy = 1'b0;
      $display("Suspend cases done");
      wr(1'b1, 1'b1, 2'h0, 8'h80);
      wp_pin = 1'b0;
      wr(1'b1, 1'bx, 2'h0, 8'h9C);
      chk(st1 & 8'hFC, 8'h80);
      wp_pin = 1'b1;
      wr(1'b1, 1'b1, 2'h0, 8'h9C);
      chk(st1 & 8'hFC, 8'h9C);
      wr(1'b1, 1'b1, 2'h0, 8'h00);
      wr(1'b1, 1'b1, 2'h1, 8'h41);
      wr(1'b1, 1'b0, 2'h0, 8'h1C);
      chk(st1 & 8'hFC, 8'h00);
      power_up = 1'b1;
      @(negedge clk);
      power_up = 1'b0;
      repeat (2) @(negedge clk);
      chk(st2, 8'h40);
      $display("Guard cases done");
      lock_req = 3'h5;
      @(negedge clk);
      lock_req = 3'h0;
      repeat (2) @(negedge clk);
      chk(8'(st2[5:3]), 8'h05);
      rst(1'b0, 2);
      wr(1'b1, 1'b1, 2'h1, 8'h40);
      chk(8'(st2[5:3]), 8'h05);
      rst(1'b1, 2);
      chk(st1 | st3 | (st2 & 8'hC7), 8'h00);
      $display("Lock cases done");
      conclude;
   end
endmodule : tb_top
`default_nettype wire
